// ==== hw/sra_pkg.sv ====
/*
  shared constants for the secured region access link: command codes,
  unlock addresses, region layout, host register map.
  assumes word addressing; base bits above the low 12 are ignored.
*/
package sra_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int REGION_WORDS = 256;
  localparam int HALF_WORDS = 128;
  localparam logic [11:0] UNLOCK_A1 = 12'h555;
  localparam logic [11:0] UNLOCK_A2 = 12'h2aa;
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_ENTER = 16'h0088;
  localparam logic [15:0] CMD_EXIT = 16'h0090;
  localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
  localparam logic [15:0] CMD_LOCK = 16'h0060;
  localparam logic [15:0] CMD_RESET = 16'h00f0;
  localparam logic [7:0] ID_LOCK_ADDR = 8'h03;
  localparam int FACT_LOCK_BIT = 7;
  localparam int CUST_LOCK_BIT = 6;
  // first sector: word addresses below this bound
  localparam logic [ADDR_W-1:0] SECTOR0_WORDS = 24'h004000;
  localparam logic [ADDR_W-1:0] BANK0_WORDS = 24'h100000;
  localparam logic [15:0] INVALID_DATA = 16'hffff;
  localparam int PROG_TIME_NS = 200;
  localparam int CLK_NS = 10;
  localparam int PROG_CYC = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int BURST_LEN = 8;
  // host register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hc;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_BURST = 3'h3;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SRA_NORMAL = 2'b00, SRA_U1 = 2'b01, SRA_U2 = 2'b11, SRA_PROG = 2'b10
  } sra_seq_e;
endpackage

// ==== hw/sra_if.sv ====
/*
  word-wide flash bus between controller and device.
  one clock; strobes are single-cycle.
*/
`timescale 1ns/1ns
interface sra_if;
  import sra_pkg::*;
  logic we;
  logic re;
  logic burst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic rvalid;
  logic busy;
  modport host (output we, re, burst, addr, wdata,
    input rdata, rvalid, busy);
  modport dev (input we, re, burst, addr, wdata,
    output rdata, rvalid, busy);
endinterface

// ==== hw/sra_region_mem.sv ====
/*
  256-word flop store of the secured region with write port.
  assumes caller gates writes for locking.
*/
`timescale 1ns/1ns
module sra_region_mem
  import sra_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // access
  input wire logic we_i,
  input wire logic [7:0] waddr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [7:0] raddr_i,
  output logic [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem [REGION_WORDS];
  genvar g;
  generate
    for (g = 0; g < REGION_WORDS; g++) begin : g_word
      // flash program only clears bits; erased state is all ones
      always_ff @(posedge clock_i) begin
        if (srst_i && g >= HALF_WORDS) begin
          mem[g] <= INVALID_DATA;
        end else if (srst_i) begin
          mem[g] <= 16'(g); // serial number stand-in
        end else if (we_i && waddr_i == 8'(g)) begin
          mem[g] <= mem[g] & wdata_i;
        end
      end
    end
  endgenerate
  assign rdata_o = mem[raddr_i];
endmodule // sra_region_mem

// ==== hw/sra_device.sv ====
/*
  device end: command decoder, region remap, lock indicators.
  assumes one bus access per cycle; array is modelled by address echo.
*/
`timescale 1ns/1ns
module sra_device
  import sra_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // link
  sra_if.dev bus,
  // status
  input wire logic embedded_busy_i,
  input wire logic accelerated_program_input_i,
  output logic region_mode_o,
  output logic customer_lock_indicator_o,
  output logic bank0_busy_o
);
  import sra_pkg::*;
  sra_seq_e seq;
  sra_seq_e next_seq;
  logic autosel;
  logic region;
  // nonvolatile lock: power-up value only, soft reset leaves it alone
  logic cust_lock = 1'b0;
  logic [7:0] burst_ptr;
  logic [DATA_W-1:0] rdata;
  logic rvalid;
  logic [7:0] prog_cnt;
  logic [DATA_W-1:0] mem_rdata;
  wire [11:0] low = bus.addr[11:0];
  wire is_u1 = bus.we && low == UNLOCK_A1 && bus.wdata == CMD_UNLOCK1;
  wire is_u2 = bus.we && low == UNLOCK_A2 && bus.wdata == CMD_UNLOCK2;
  wire is_cmd = bus.we && seq == SRA_U2 && low == UNLOCK_A1;
  wire in_s0 = bus.addr < SECTOR0_WORDS;
  wire in_range = bus.addr < ADDR_W'(REGION_WORDS);
  wire busy = prog_cnt != 8'h00 || embedded_busy_i;
  wire prog_wr = bus.we && seq == SRA_PROG && region && in_s0;
  wire cust_ok = bus.addr[7] && in_range && !cust_lock;
  wire mem_we = prog_wr && cust_ok && !busy;
  wire [7:0] raddr = bus.burst ? burst_ptr : bus.addr[7:0];
  wire lock_wr = is_cmd && bus.wdata == CMD_LOCK && region;
  wire [DATA_W-1:0] id_word =
    {8'h00, 1'b1, cust_lock, 6'h00};

  sra_region_mem u_mem (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .we_i(mem_we),
    .waddr_i(bus.addr[7:0]),
    .wdata_i(bus.wdata),
    .raddr_i(raddr),
    .rdata_o(mem_rdata)
  );

  always_comb begin
    next_seq = seq;
    case (seq)
      SRA_NORMAL: if (is_u1) next_seq = SRA_U1;
      SRA_U1: if (bus.we) next_seq = is_u2 ? SRA_U2 : SRA_NORMAL;
      SRA_U2: begin
        if (bus.we) begin
          next_seq = (is_cmd && bus.wdata == CMD_PROGRAM)
            ? SRA_PROG : SRA_NORMAL;
        end
      end
      SRA_PROG: if (bus.we) next_seq = SRA_NORMAL;
      default: next_seq = SRA_NORMAL;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      seq <= SRA_NORMAL;
      region <= 1'b0;
      autosel <= 1'b0;
    end else begin
      seq <= next_seq;
      if (is_cmd && bus.wdata == CMD_ENTER) begin
        region <= 1'b1;
      end else if (is_cmd && bus.wdata == CMD_EXIT && region) begin
        region <= 1'b0;
      end else if (is_cmd && bus.wdata == CMD_AUTOSEL) begin
        autosel <= 1'b1;
      end
      if (bus.we && bus.wdata == CMD_RESET) begin
        autosel <= 1'b0;
      end
    end
  end

  // lock state lives in flash; kept here in flops across soft reset
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      prog_cnt <= 8'h00;
    end else if (mem_we) begin
      prog_cnt <= 8'(PROG_CYC);
    end else if (prog_cnt != 8'h00) begin
      prog_cnt <= prog_cnt - 8'h01;
    end
  end
  always_ff @(posedge clock_i) begin
    if (lock_wr && !busy) begin
      cust_lock <= 1'b1;
    end
  end

  // burst pointer wraps inside the region
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      burst_ptr <= 8'h00;
    end else if (bus.re && !bus.burst) begin
      burst_ptr <= bus.addr[7:0] + 8'h01;
    end else if (bus.re) begin
      burst_ptr <= burst_ptr + 8'h01;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= bus.re;
      if (bus.re && autosel && bus.addr[7:0] == ID_LOCK_ADDR) begin
        rdata <= id_word;
      end else if (bus.re && region && in_s0) begin
        rdata <= (busy || (!in_range && !bus.burst))
          ? INVALID_DATA : mem_rdata;
      end else if (bus.re) begin
        rdata <= bus.addr[15:0];
      end
    end
  end

  assign bus.rdata = rdata;
  assign bus.rvalid = rvalid;
  assign bus.busy = busy;
  assign region_mode_o = region;
  assign customer_lock_indicator_o = cust_lock;
  // accelerated and bypass paths ignored while in region
  assign bank0_busy_o = region || (busy &&
    !accelerated_program_input_i);
endmodule // sra_device

// ==== hw/sra_host.sv ====
/*
  host end: AXI4-Lite slave turning register writes into flash
  bus cycles. assumes software builds command sequences word by word.
*/
`timescale 1ns/1ns
module sra_host
  import sra_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // axi write
  input wire logic [3:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  // axi read
  input wire logic [3:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // link
  sra_if.host bus
);
  import sra_pkg::*;
  logic aw_got, w_got, bvalid, rvalid;
  logic [3:0] awaddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dword;
  logic we, re, burst, pending;
  wire do_wr = aw_got && w_got && !bvalid;
  wire addr_ok = awaddr == REG_CTRL || awaddr == REG_ADDR ||
    awaddr == REG_DATA;
  wire [2:0] op = wdata[2:0];
  wire start = do_wr && awaddr == REG_CTRL && !pending;
  wire [31:0] stat_word = {29'h0, bus.busy, pending, 1'b0};
  assign s_awready_o = !aw_got && !bvalid;
  assign s_wready_o = !w_got && !bvalid;
  assign s_arready_o = !rvalid;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      bvalid <= 1'b0;
      bresp <= AXI_OKAY;
      awaddr <= 4'h0;
      wdata <= 32'h0;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_got <= 1'b1;
        awaddr <= s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_got <= 1'b1;
        wdata <= s_wdata_i;
      end
      if (do_wr) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= addr_ok ? AXI_OKAY : AXI_SLVERR;
      end else if (bvalid && s_bready_i) begin
        bvalid <= 1'b0;
      end
    end
  end

  // registers and one-cycle flash strobes
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      addr <= '0;
      dword <= 16'h0000;
      we <= 1'b0;
      re <= 1'b0;
      burst <= 1'b0;
      pending <= 1'b0;
    end else begin
      we <= start && op == OP_WRITE;
      re <= start && (op == OP_READ || op == OP_BURST);
      burst <= start && op == OP_BURST;
      if (do_wr && awaddr == REG_ADDR) addr <= wdata[ADDR_W-1:0];
      if (do_wr && awaddr == REG_DATA) dword <= wdata[15:0];
      if (start && op != OP_WRITE) pending <= 1'b1;
      if (bus.rvalid) begin
        pending <= 1'b0;
        dword <= bus.rdata;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= AXI_OKAY;
    end else if (s_arvalid_i && s_arready_o) begin
      rvalid <= 1'b1;
      rresp <= AXI_OKAY;
      case (s_araddr_i)
        REG_CTRL: rdata <= 32'h0;
        REG_ADDR: rdata <= {8'h00, addr};
        REG_DATA: rdata <= {16'h0000, dword};
        REG_STAT: rdata <= stat_word;
        default: begin
          rdata <= 32'h0;
          rresp <= AXI_SLVERR;
        end
      endcase
    end else if (rvalid && s_rready_i) begin
      rvalid <= 1'b0;
    end
  end

  assign s_bvalid_o = bvalid;
  assign s_bresp_o = bresp;
  assign s_rvalid_o = rvalid;
  assign s_rdata_o = rdata;
  assign s_rresp_o = rresp;
  assign bus.we = we;
  assign bus.re = re;
  assign bus.burst = burst;
  assign bus.addr = addr;
  assign bus.wdata = dword;
endmodule // sra_host

// ==== test/sra_link_properties.sv ====
/*
  link checker for the secured region pair.
  assumes rvalid one cycle after re and a registered mode flag.
*/
`timescale 1ns/1ns
module sra_link_properties (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // link
  input wire logic we,
  input wire logic re,
  input wire logic [sra_pkg::ADDR_W-1:0] addr,
  input wire logic [sra_pkg::DATA_W-1:0] wdata,
  input wire logic [sra_pkg::DATA_W-1:0] rdata,
  input wire logic rvalid,
  input wire logic busy,
  // device status
  input wire logic region_mode_o,
  input wire logic customer_lock_indicator_o
);
  import sra_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  sequence read_req;
    re ##1 rvalid;
  endsequence
  sequence region_miss;
    $past(region_mode_o && addr < SECTOR0_WORDS &&
      (busy || addr >= 24'h000100));
  endsequence
  read_answer_a: assert property (re |-> read_req)
    else $error("read strobe without data valid");
  stray_valid_a: assert property (rvalid |-> $past(re))
    else $error("data valid without read strobe");
  reset_normal_a: assert property ($fell(srst_i) |-> !region_mode_o)
    else $error("region mode survives reset");
  enter_cmd_a: assert property ($rose(region_mode_o) |->
    $past(we && addr[11:0] == UNLOCK_A1 && wdata == CMD_ENTER))
    else $error("region mode entered without enter command");
  exit_cmd_a: assert property ($fell(region_mode_o) && !$past(srst_i) |->
    $past(we && addr[11:0] == UNLOCK_A1 && wdata == CMD_EXIT))
    else $error("region mode left without exit command");
  lock_sticks_a: assert property (
    customer_lock_indicator_o |=> customer_lock_indicator_o)
    else $error("customer lock cleared");
  region_blank_a: assert property (
    rvalid ##0 region_miss |-> rdata == INVALID_DATA)
    else $error("blocked region read returned data");
  other_sector_a: assert property (rvalid &&
    $past(region_mode_o && addr >= SECTOR0_WORDS) |->
    rdata == $past(addr[15:0]))
    else $error("other sector read not array data");
endmodule // sra_link_properties

// ==== test/secure_region_access_tb.sv ====
/*
  bench: host and device joined by the link, driven over axi.
  assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ns
module secure_region_access_tb;
  import sra_pkg::*;
  logic clock_i = 1'h0;
  logic srst_i = 1'h1;
  logic [3:0] s_awaddr_i = 4'h0, s_araddr_i = 4'h0, s_wstrb_i = 4'hf;
  logic s_awvalid_i = 1'h0, s_wvalid_i = 1'h0, s_bready_i = 1'h0;
  logic s_arvalid_i = 1'h0, s_rready_i = 1'h0;
  logic [31:0] s_wdata_i = 32'h0;
  logic embedded_busy_i = 1'h0, accelerated_program_input_i = 1'h0;
  logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
  logic [1:0] s_bresp_o, s_rresp_o;
  logic [31:0] s_rdata_o;
  logic region_mode_o, customer_lock_indicator_o, bank0_busy_o;
  logic [15:0] cust [128];
  int n_mismatch = 0, checks = 0, seed = 41551;
  sra_if link();
  sra_host sra_host_i(.clock_i, .srst_i, .s_awaddr_i, .s_awvalid_i,
    .s_awready_o, .s_wdata_i, .s_wstrb_i, .s_wvalid_i, .s_wready_o,
    .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i,
    .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i,
    .bus(link.host));
  sra_device sra_device_i(.clock_i, .srst_i, .bus(link.dev),
    .embedded_busy_i, .accelerated_program_input_i, .region_mode_o,
    .customer_lock_indicator_o, .bank0_busy_o);
  sra_link_properties sra_link_properties_i(.clock_i, .srst_i,
    .we(link.we), .re(link.re), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .rvalid(link.rvalid), .busy(link.busy),
    .region_mode_o, .customer_lock_indicator_o);
  always #5 clock_i = ~clock_i;
  task automatic stop_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input bit ok);
    if (!ok) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  task automatic aw(input logic [3:0] a, input logic [31:0] d,
      input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge clock_i);
    s_awaddr_i <= a;
    s_wdata_i <= d;
    s_awvalid_i <= 1'h1;
    s_wvalid_i <= 1'h1;
    s_bready_i <= 1'h1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clock_i);
      if (s_awready_o) s_awvalid_i <= 1'h0;
      if (s_wready_o) s_wvalid_i <= 1'h0;
      if (s_bvalid_o === 1'h1) begin
        s_bready_i <= 1'h0;
        chk({14'h0, s_bresp_o}, {14'h0, er});
        done = 1;
      end
    end
    tmo(done);
  endtask
  task automatic ar(input logic [3:0] a, output logic [31:0] d);
    bit done;
    done = 0;
    @(posedge clock_i);
    s_araddr_i <= a;
    s_arvalid_i <= 1'h1;
    s_rready_i <= 1'h1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clock_i);
      if (s_arready_o) s_arvalid_i <= 1'h0;
      if (s_rvalid_o === 1'h1) begin
        s_rready_i <= 1'h0;
        d = s_rdata_o;
        chk({14'h0, s_rresp_o},
          {14'h0, (a[1:0] == 2'h0) ? AXI_OKAY : AXI_SLVERR});
        done = 1;
      end
    end
    tmo(done);
  endtask
  task automatic fw(input logic [23:0] a, input logic [15:0] d);
    aw(REG_ADDR, {8'h0, a}, AXI_OKAY);
    aw(REG_DATA, {16'h0, d}, AXI_OKAY);
    aw(REG_CTRL, {29'h0, OP_WRITE}, AXI_OKAY);
  endtask
  task automatic fr(input logic [23:0] a, input logic [2:0] op,
      output logic [15:0] d);
    logic [31:0] r;
    aw(REG_ADDR, {8'h0, a}, AXI_OKAY);
    aw(REG_CTRL, {29'h0, op}, AXI_OKAY);
    r = 32'h2;
    for (int n = 0; n < 20 && r[1]; n++) ar(REG_STAT, r);
    tmo(r[1] === 1'h0);
    ar(REG_DATA, r);
    d = r[15:0];
  endtask
  // three unlock style cycles ending in a command word
  task automatic cmd(input logic [15:0] c);
    fw({12'h0, UNLOCK_A1}, CMD_UNLOCK1);
    fw({12'h0, UNLOCK_A2}, CMD_UNLOCK2);
    fw({12'h0, UNLOCK_A1}, c);
    // the device took the strobe on the edge fw returned on; wait one more edge so mode flags have settled
    @(posedge clock_i);
  endtask
  task automatic idle();
    logic [31:0] r;
    r = 32'h4;
    for (int n = 0; n < 40 && r[2]; n++) ar(REG_STAT, r);
    tmo(r[2] === 1'h0);
  endtask
  function automatic logic [15:0] region_word(input logic [7:0] a);
    return a[7] ? cust[a[6:0]] : {8'h0, a};
  endfunction
  initial begin
    logic [15:0] d, wd;
    logic [23:0] ra;
    logic [31:0] w;
    foreach (cust[i]) cust[i] = 16'hffff;
    repeat (6) @(posedge clock_i);
    srst_i <= 1'h0;
    aw(4'h2, 32'h0, AXI_SLVERR);
    ar(4'h2, w);
    for (int i = 0; i < 4; i++) begin
      ra = 24'($random(seed));
      fr(ra, OP_READ, d);
      chk(d, ra[15:0]);
    end
    cmd(CMD_AUTOSEL);
    fr(24'h000003, OP_READ, d);
    chk({14'h0, d[7:6]}, 16'h0002);
    fw(24'h000000, CMD_RESET);
    cmd(CMD_ENTER);
    chk({15'h0, region_mode_o}, 16'h0001);
    chk({15'h0, bank0_busy_o}, 16'h0001);
    for (int i = 0; i < 6; i++) begin
      ra = 24'($random(seed)) & 24'h0000ff;
      fr(ra, OP_READ, d);
      chk(d, region_word(ra[7:0]));
    end
    fr(24'h000100, OP_READ, d);
    chk(d, INVALID_DATA);
    fr(24'h004010, OP_READ, d);
    chk(d, 16'h4010);
    embedded_busy_i <= 1'h1;
    fr(24'h000005, OP_READ, d);
    chk(d, INVALID_DATA);
    embedded_busy_i <= 1'h0;
    ra = 24'h000080 | (24'($random(seed)) & 24'h00007f);
    wd = 16'($random(seed));
    accelerated_program_input_i <= 1'h1;
    cmd(CMD_PROGRAM);
    fw(ra, wd);
    ar(REG_STAT, w);
    chk({15'h0, w[2]}, 16'h0001);
    idle();
    accelerated_program_input_i <= 1'h0;
    cust[ra[6:0]] = wd;
    fr(ra, OP_READ, d);
    chk(d, region_word(ra[7:0]));
    cmd(CMD_PROGRAM);
    fw(24'h000005, 16'h0000);
    idle();
    fr(24'h000005, OP_READ, d);
    chk(d, 16'h0005);
    cmd(CMD_LOCK);
    chk({15'h0, customer_lock_indicator_o}, 16'h0001);
    ra = ra ^ 24'h000001;
    cmd(CMD_PROGRAM);
    fw(ra, 16'h0000);
    idle();
    fr(ra, OP_READ, d);
    chk(d, region_word(ra[7:0]));
    fr(24'h0000ff, OP_READ, d);
    fr(24'h0000ff, OP_BURST, d);
    chk(d, region_word(8'h00));
    cmd(CMD_EXIT);
    chk({15'h0, region_mode_o}, 16'h0000);
    chk({15'h0, bank0_busy_o}, 16'h0000);
    fr(24'h000020, OP_READ, d);
    chk(d, 16'h0020);
    cmd(CMD_AUTOSEL);
    fr(24'h000003, OP_READ, d);
    chk({14'h0, d[7:6]}, 16'h0003);
    fw(24'h000000, CMD_RESET);
    // reset in mid mode must land in normal addressing
    cmd(CMD_ENTER);
    srst_i <= 1'h1;
    @(posedge clock_i);
    srst_i <= 1'h0;
    fr(24'h000040, OP_READ, d);
    chk(d, 16'h0040);
    chk({15'h0, customer_lock_indicator_o}, 16'h0001);
    stop_test();
  end
endmodule // secure_region_access_tb
